//--- shared/sfpi_params.svh
// offsets, field positions, reset values and counts of the serial flash pin interface
`ifndef SFPI_PARAMS_SVH
`define SFPI_PARAMS_SVH
// apb register byte offsets
`define SFPI_OFS_CTRL 8'h00
`define SFPI_OFS_PROT 8'h04
`define SFPI_OFS_TXDATA 8'h08
`define SFPI_OFS_RXDATA 8'h0c
`define SFPI_OFS_STATE 8'h10
`define SFPI_OFS_RANGE 8'h14
`define SFPI_OFS_TARGET 8'h18
`define SFPI_OFS_MAP 8'h1c
// control register fields
`define SFPI_CTRL_LANE_LSB 0
`define SFPI_CTRL_DIR_BIT 2
`define SFPI_CTRL_CLR_BIT 3
// protect register fields (copies of status register one/two bits)
`define SFPI_PROT_STATUS_PROTECT_BIT_ZERO_BIT 0
`define SFPI_PROT_STATUS_PROTECT_BIT_ONE_BIT 1
`define SFPI_PROT_QE_BIT 2
`define SFPI_PROT_CMP_BIT 3
// range register fields
`define SFPI_RANGE_LO_LSB 0
`define SFPI_RANGE_HI_LSB 16
// map register fields
`define SFPI_MAP_SECTOR_LSB 0
`define SFPI_MAP_HALF_LSB 12
`define SFPI_MAP_BLOCK_LSB 20
`define SFPI_MAP_ARRAY_BIT 31
// array address layout
`define SFPI_ADDR_TOP 20
`define SFPI_SECTOR_LSB 12
`define SFPI_HALF_LSB 15
`define SFPI_BLOCK_LSB 16
// reset values
`define SFPI_RST_TXDATA 8'hff
`define SFPI_RST_RANGE_HI 9'h1ff
// bits per serial byte
`define SFPI_BYTE_BITS 4'h8
`endif

//--- shared/sfpi_pkg.sv
// types shared by the serial flash pin interface
package sfpi_pkg;
  // link state, one-hot
  typedef enum logic [3:0] {
    SFPI_WAIT = 4'h1,
    SFPI_IDLE = 4'h2,
    SFPI_ACTIVE = 4'h4,
    SFPI_PAUSE = 4'h8
  } sfpi_link_type;
  // lane setting written by software
  typedef enum logic [1:0] {
    SFPI_LANE1 = 2'h0,
    SFPI_LANE2 = 2'h1,
    SFPI_LANE4 = 2'h2
  } sfpi_lane_type;
endpackage : sfpi_pkg

//--- verilog/sfpi_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module sfpi_sync #(
  parameter int WIDTH = 6
) (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // pins and synchronised copies
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  // both stages; first is read only by the second
  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } sfpi_sync_state_type;

  sfpi_sync_state_type cur;
  sfpi_sync_state_type next_cur;

  // shift the pins through two stages
  always_comb begin
    next_cur = cur;
    next_cur.first = async_in;
    next_cur.second = cur.first;
  end

  // register the stages
  always_ff @(posedge mclk) begin
    if (srst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign sync_out = cur.second;
endmodule : sfpi_sync
`default_nettype wire

//--- verilog/sfpi_addr_map.sv
// splits a 24-bit array address into block, half-block and sector indices
`timescale 1ns/1ns
`default_nettype none
`include "sfpi_params.svh"
module sfpi_addr_map (
  // address in
  input wire logic [23:0] addr,
  // indices out
  output logic [4:0] block_idx,
  output logic [5:0] half_idx,
  output logic [8:0] sector_idx,
  output logic in_array
);
  // field between the array top bit and a given low bit
  function automatic logic [8:0] sfpi_field(input logic [23:0] a, input int lsb);
    logic [20:0] low;
    low = a[`SFPI_ADDR_TOP:0];
    return 9'(low >> lsb);
  endfunction : sfpi_field

  // 4 KB sectors, eight per half block, sixteen per block
  assign sector_idx = sfpi_field(addr, `SFPI_SECTOR_LSB);
  assign half_idx = 6'(sfpi_field(addr, `SFPI_HALF_LSB));
  assign block_idx = 5'(sfpi_field(addr, `SFPI_BLOCK_LSB));
  // array spans 000000h to 1fffffh only
  assign in_array = (addr[23:21] == 3'h0);
endmodule : sfpi_addr_map
`default_nettype wire

//--- verilog/sfpi_top.sv
// serial flash pin interface: select, pause, protect and lane shifting
// Overview of operation
// - deselected: inputs ignored, outputs high impedance
// - standby when deselected and no operation busy
// - first instruction only after select falling edge
// - capture input bits on clock rising edge
// - change output bits after clock falling edge
// - dual/quad: lines zero, one bidirectional
// - protect pin low, bits 0/1: reject writes
// - hardware protect blocks protected region modification
// - quad enable disables protect, pin is data
// - pause only without quad enable
// - pause starts with clock low
// - pause ends with clock low
// - pause leaves internal operations running
// - 512 sectors of 4 KB, half/blocks
// - clock modes 0 and 3 both work
// - paused: output high impedance, inputs ignored
// - deselect while paused resets interface
`timescale 1ns/1ns
`default_nettype none
`include "sfpi_params.svh"
module sfpi_top
  import sfpi_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // flash pins from the host
  input wire logic chip_select_n,
  input wire logic serial_clock,
  input wire logic data_line_zero_in,
  output logic data_line_zero_out,
  output logic data_line_zero_oe,
  input wire logic data_line_one_in,
  output logic data_line_one_out,
  output logic data_line_one_oe,
  input wire logic data_line_two_in,
  output logic data_line_two_out,
  output logic data_line_two_oe,
  input wire logic data_line_three_in,
  output logic data_line_three_out,
  output logic data_line_three_oe,
  // internal core status
  input wire logic op_busy,
  output logic standby,
  output logic link_active,
  output logic hw_protected,
  output logic modify_blocked
);
  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    sfpi_link_type link;  // link state
    logic cs_prev;  // select one cycle ago
    logic sclk_prev;  // serial clock one cycle ago
    logic rise_seen;  // a rising edge happened in this frame
    sfpi_lane_type lanes;  // lane setting
    logic dir_tx;  // device drives data
    logic status_protect_bit_zero;  // status_protect_bit_zero
    logic status_protect_bit_one;  // status_protect_bit_one
    logic qe;  // quad_enable_bit
    logic cmp;  // complement_protect_bit
    logic [7:0] tx_data;  // next byte to send
    logic [7:0] rx_data;  // last byte received
    logic rx_valid;  // sticky byte-received flag
    logic wr_rejected;  // sticky rejected protect write
    logic [8:0] prot_lo;  // first protected sector
    logic [8:0] prot_hi;  // last protected sector
    logic [23:0] target;  // address under test
    logic [7:0] rx_shift;  // receive shifter
    logic [3:0] rx_cnt;  // bits received in byte
    logic [7:0] tx_shift;  // transmit shifter, current bits on top
    logic [3:0] tx_cnt;  // bits sent in byte
    logic [31:0] prdata;  // read data
    logic pslverr;  // unmapped access
  } sfpi_state_type;

  sfpi_state_type cur;
  sfpi_state_type next_cur;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [5:0] pins_sync;
  sfpi_sync #(.WIDTH(6)) u_sync (
    .mclk(mclk),
    .srst(srst),
    .async_in({chip_select_n, serial_clock, data_line_three_in, data_line_two_in,
               data_line_one_in, data_line_zero_in}),
    .sync_out(pins_sync)
  );
  logic s_cs_n;  // synchronised select
  logic s_sclk;  // synchronised serial clock
  logic [3:0] s_d;  // synchronised data lines
  assign s_cs_n = pins_sync[5];
  assign s_sclk = pins_sync[4];
  assign s_d = pins_sync[3:0];

  ////////////////////////////////////////////////////////////////////////////
  // address map of the target register
  logic [4:0] map_block;
  logic [5:0] map_half;
  logic [8:0] map_sector;
  logic map_in_array;
  sfpi_addr_map u_map (
    .addr(cur.target),
    .block_idx(map_block),
    .half_idx(map_half),
    .sector_idx(map_sector),
    .in_array(map_in_array)
  );

  ////////////////////////////////////////////////////////////////////////////
  // functions
  // active lane count; quad falls back to single without quad enable
  function automatic logic [3:0] sfpi_width(input sfpi_lane_type l, input logic q);
    case (l)
      SFPI_LANE2: return 4'h2;
      SFPI_LANE4: return q ? 4'h4 : 4'h1;
      default: return 4'h1;
    endcase
  endfunction : sfpi_width

  // shift received lanes in, msb first
  function automatic logic [7:0] sfpi_shift_in(input logic [7:0] s, input logic [3:0] d,
                                               input logic [3:0] w);
    case (w)
      4'h1: return {s[6:0], d[0]};
      4'h2: return {s[5:0], d[1:0]};
      default: return {s[3:0], d};
    endcase
  endfunction : sfpi_shift_in

  // decoded apb offsets
  function automatic logic sfpi_mapped(input logic [7:0] a);
    case (a)
      `SFPI_OFS_CTRL, `SFPI_OFS_PROT, `SFPI_OFS_TXDATA, `SFPI_OFS_RXDATA,
      `SFPI_OFS_STATE, `SFPI_OFS_RANGE, `SFPI_OFS_TARGET, `SFPI_OFS_MAP: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : sfpi_mapped

  ////////////////////////////////////////////////////////////////////////////
  // derived levels
  logic [3:0] lw;  // active lane width
  logic rise;  // serial clock rising
  logic fall;  // serial clock falling
  logic cs_fall;  // select falling
  logic pause_n;  // effective pause pin, high when not pausing
  logic in_region;  // target inside the selected region
  logic apb_wr;  // mapped write in access phase
  logic rx_en;  // receiving allowed
  logic drive;  // device drives data lines
  assign lw = sfpi_width(cur.lanes, cur.qe);
  // edges found from the sampled clock
  assign rise = s_sclk && !cur.sclk_prev;
  assign fall = !s_sclk && cur.sclk_prev;
  assign cs_fall = !s_cs_n && cur.cs_prev;
  // pause pin is pure data with quad enable
  assign pause_n = cur.qe ? 1'b1 : s_d[3];
  // protect pin disabled with quad enable
  assign hw_protected = !cur.qe && !s_d[2] && cur.status_protect_bit_zero && !cur.status_protect_bit_one;
  assign in_region = map_in_array && ((map_sector >= cur.prot_lo && map_sector <= cur.prot_hi) ^ cur.cmp);
  assign modify_blocked = hw_protected && in_region;
  assign apb_wr = psel && penable && pwrite && sfpi_mapped(paddr);
  // in multi-lane send the lines carry our own data, so do not receive
  assign rx_en = !cur.dir_tx || (lw == 4'h1);

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic frame_start;
    logic [3:0] cnt;
    logic [31:0] rd;
    frame_start = 1'b0;
    cnt = 4'h0;
    rd = 32'h0;
    next_cur = cur;
    next_cur.cs_prev = s_cs_n;
    next_cur.sclk_prev = s_sclk;
    // read data is captured in the setup phase, so it is a flop in access
    if (psel && !penable) begin
      case (paddr)
        `SFPI_OFS_CTRL: rd = {29'h0, cur.dir_tx, cur.lanes};
        `SFPI_OFS_PROT: rd = {28'h0, cur.cmp, cur.qe, cur.status_protect_bit_one, cur.status_protect_bit_zero};
        `SFPI_OFS_TXDATA: rd = {24'h0, cur.tx_data};
        `SFPI_OFS_RXDATA: rd = {24'h0, cur.rx_data};
        `SFPI_OFS_STATE: rd = {24'h0, modify_blocked, cur.wr_rejected, hw_protected,
                               cur.rx_valid, cur.link};
        `SFPI_OFS_RANGE: rd = {7'h0, cur.prot_hi, 7'h0, cur.prot_lo};
        `SFPI_OFS_TARGET: rd = {8'h0, cur.target};
        `SFPI_OFS_MAP: rd = {map_in_array, 6'h0, map_block, 2'h0, map_half, 3'h0, map_sector};
        default: rd = 32'h0;
      endcase
      next_cur.prdata = rd;
      next_cur.pslverr = !sfpi_mapped(paddr);
    end
    // register writes
    if (apb_wr) begin
      case (paddr)
        `SFPI_OFS_CTRL: begin
          next_cur.lanes = sfpi_lane_type'(pwdata[`SFPI_CTRL_LANE_LSB +: 2]);
          next_cur.dir_tx = pwdata[`SFPI_CTRL_DIR_BIT];
          if (pwdata[`SFPI_CTRL_CLR_BIT]) begin
            next_cur.rx_valid = 1'b0;
            next_cur.wr_rejected = 1'b0;
          end
        end
        `SFPI_OFS_PROT: begin
          // protect bits frozen while hardware protected
          if (hw_protected) begin
            next_cur.wr_rejected = 1'b1;
          end else begin
            next_cur.status_protect_bit_zero = pwdata[`SFPI_PROT_STATUS_PROTECT_BIT_ZERO_BIT];
            next_cur.status_protect_bit_one = pwdata[`SFPI_PROT_STATUS_PROTECT_BIT_ONE_BIT];
            next_cur.qe = pwdata[`SFPI_PROT_QE_BIT];
            next_cur.cmp = pwdata[`SFPI_PROT_CMP_BIT];
          end
        end
        `SFPI_OFS_TXDATA: next_cur.tx_data = pwdata[7:0];
        `SFPI_OFS_RANGE: begin
          // region moves are refused like status writes
          if (hw_protected) begin
            next_cur.wr_rejected = 1'b1;
          end else begin
            next_cur.prot_lo = pwdata[`SFPI_RANGE_LO_LSB +: 9];
            next_cur.prot_hi = pwdata[`SFPI_RANGE_HI_LSB +: 9];
          end
        end
        `SFPI_OFS_TARGET: next_cur.target = pwdata[23:0];
        default: next_cur.target = cur.target;  // read-only offsets
      endcase
    end
    // link state machine
    case (cur.link)
      SFPI_WAIT: begin
        // armed only by a select falling edge after reset
        if (cs_fall) begin
          next_cur.link = SFPI_ACTIVE;
          frame_start = 1'b1;
        end
      end
      SFPI_IDLE: begin
        // select low makes the device active
        if (!s_cs_n) begin
          next_cur.link = SFPI_ACTIVE;
          frame_start = 1'b1;
        end
      end
      SFPI_ACTIVE: begin
        if (s_cs_n) begin
          next_cur.link = SFPI_IDLE;
        end else if (!pause_n && !s_sclk) begin
          // pause starts once the clock is low
          next_cur.link = SFPI_PAUSE;
        end else begin
          // output waits for a rise, so mode 3 first fall is skipped
          if (rise) begin
            next_cur.rise_seen = 1'b1;
            // lines zero and one receive in dual, all four lines in quad
            if (rx_en) begin
              next_cur.rx_shift = sfpi_shift_in(cur.rx_shift, s_d, lw);
              cnt = cur.rx_cnt + lw;
              if (cnt == `SFPI_BYTE_BITS) begin
                next_cur.rx_data = next_cur.rx_shift;
                next_cur.rx_valid = 1'b1;  // set wins over the clear above
                next_cur.rx_cnt = 4'h0;
              end else begin
                next_cur.rx_cnt = cnt;
              end
            end
          end
          // output moves only after a falling edge
          if (fall && cur.rise_seen && cur.dir_tx) begin
            cnt = cur.tx_cnt + lw;
            if (cnt == `SFPI_BYTE_BITS) begin
              next_cur.tx_shift = cur.tx_data;
              next_cur.tx_cnt = 4'h0;
            end else begin
              next_cur.tx_shift = cur.tx_shift << lw;
              next_cur.tx_cnt = cnt;
            end
          end
        end
      end
      SFPI_PAUSE: begin
        // clock and data ignored while paused
        if (s_cs_n) begin
          // deselect during pause drops the partial instruction
          next_cur.link = SFPI_IDLE;
          next_cur.rx_cnt = 4'h0;
          next_cur.tx_cnt = 4'h0;
        end else if (pause_n && !s_sclk) begin
          // pause ends once the clock is low
          next_cur.link = SFPI_ACTIVE;
        end
      end
      default: next_cur.link = SFPI_WAIT;
    endcase
    // new frame: fresh counters, first byte preloaded before any rise
    if (frame_start) begin
      next_cur.rx_cnt = 4'h0;
      next_cur.tx_cnt = 4'h0;
      next_cur.rise_seen = 1'b0;
      next_cur.tx_shift = cur.tx_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge mclk) begin
    if (srst) begin
      cur <= '0;
      cur.link <= SFPI_WAIT;
      cur.tx_data <= `SFPI_RST_TXDATA;
      cur.prot_hi <= `SFPI_RST_RANGE_HI;
    end else begin
      cur <= next_cur;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  // drive only while active and sending
  assign drive = (cur.link == SFPI_ACTIVE) && cur.dir_tx;
  // lanes used for output follow the width
  assign data_line_three_out = cur.tx_shift[7];
  assign data_line_two_out = cur.tx_shift[6];
  assign data_line_one_out = (lw == 4'h4) ? cur.tx_shift[5] : cur.tx_shift[7];
  assign data_line_zero_out = (lw == 4'h4) ? cur.tx_shift[4] : cur.tx_shift[6];
  assign data_line_one_oe = drive;
  assign data_line_zero_oe = drive && (lw != 4'h1);
  assign data_line_two_oe = drive && (lw == 4'h4);
  assign data_line_three_oe = drive && (lw == 4'h4);
  // standby while deselected and idle inside
  // busy is independent of pause, operations keep running
  assign standby = (cur.link == SFPI_WAIT || cur.link == SFPI_IDLE) && !op_busy;
  assign link_active = (cur.link == SFPI_ACTIVE) || (cur.link == SFPI_PAUSE);
  assign prdata = cur.prdata;
  assign pslverr = cur.pslverr;
  assign pready = 1'b1;  // every access completes in one access cycle

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  sequence s_pause_low;
    (cur.link == SFPI_ACTIVE) && !s_cs_n && !s_d[3] && !s_sclk;
  endsequence
  sequence s_pause_high_clk;
    (cur.link == SFPI_PAUSE) && !s_cs_n && s_sclk;
  endsequence

  a_deselect_hiz: assert property (s_cs_n [*3] |-> !data_line_one_oe && !data_line_zero_oe)
    else $error("outputs driven while deselected");
  a_standby_busy: assert property (op_busy |-> !standby)
    else $error("standby while an operation runs");
  a_wait_edge: assert property ((cur.link == SFPI_WAIT) && !cs_fall |=> cur.link == SFPI_WAIT)
    else $error("armed without a select falling edge");
  a_rise_capture: assert property ((cur.link == SFPI_ACTIVE) && !s_cs_n && pause_n && rise && rx_en
      && lw == 4'h1 && cur.rx_cnt == 4'h7 |=> cur.rx_valid && cur.rx_data[0] == $past(s_d[0]))
    else $error("byte not captured on rising edge");
  a_fall_update: assert property ($changed(cur.tx_shift) && $past(cur.link) == SFPI_ACTIVE
      && cur.link == SFPI_ACTIVE |-> $past(fall))
    else $error("output changed without a falling edge");
  a_wp_reject: assert property (apb_wr && paddr == `SFPI_OFS_PROT && hw_protected
      |=> cur.wr_rejected && cur.status_protect_bit_zero == $past(cur.status_protect_bit_zero) && cur.qe == $past(cur.qe))
    else $error("protect write taken while protected");
  a_quad_no_wp: assert property (cur.qe |-> !hw_protected && !modify_blocked)
    else $error("protect active with quad enable");
  a_quad_no_pause: assert property (cur.qe && (cur.link == SFPI_ACTIVE) && !s_cs_n
      |=> cur.link != SFPI_PAUSE)
    else $error("pause taken with quad enable");
  a_pause_enter: assert property (s_pause_low and !cur.qe |=> cur.link == SFPI_PAUSE)
    else $error("pause not entered with clock low");
  a_pause_hold: assert property (s_pause_high_clk |=> cur.link == SFPI_PAUSE)
    else $error("pause left with clock high");
  a_pause_hiz: assert property ((cur.link == SFPI_PAUSE) |-> !data_line_one_oe && !data_line_three_oe)
    else $error("output driven while paused");
  a_pause_abort: assert property ((cur.link == SFPI_PAUSE) && s_cs_n
      |=> cur.link == SFPI_IDLE && cur.rx_cnt == 4'h0)
    else $error("deselect in pause did not reset");
endmodule : sfpi_top
`default_nettype wire

//--- test/sfpi_host_model.sv
// host spi controller model driving the flash pins
`timescale 1ns/1ns
`default_nettype none
module sfpi_host_model (
  // pins toward the device
  output logic cs_n,
  output logic sclk,
  output logic d0,
  output logic d2,
  output logic d3,
  // device output line
  input wire logic d1
);
  // powers up selected, so arming needs a later falling edge
  initial begin
    cs_n = 1'b0;
    sclk = 1'b0;
    d0 = 1'b0;
    d2 = 1'b1;
    d3 = 1'b1;
  end
  // select, clock idle level, pause and protect levels
  task automatic pins(input logic c, input logic k, input logic h, input logic w);
    cs_n <= c;
    sclk <= k;
    d3 <= h;
    d2 <= w;
    #125;
  endtask : pins
  // msb first; data set while clock low, read back at the rise
  task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      sclk <= 1'b0;
      d0 <= tx[i];
      #62;
      sclk <= 1'b1;
      rx[i] = d1;
      #63;
    end
    // last low phase is kept, so the closing fall is never swallowed by the next call
    sclk <= 1'b0;
    #62;
  endtask : xfer
endmodule : sfpi_host_model
`default_nettype wire

//--- test/sfpi_top_tb.sv
// self-checking testbench of the serial flash pin interface
`timescale 1ns/1ns
`default_nettype none
`include "sfpi_params.svh"
module sfpi_top_tb;
  // clock, reset and apb
  logic mclk, srst, psel, penable, pwrite, pready, pslverr, last_err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  // pins and status
  logic cs_n, sclk, d0, d2, d3, tgl, op_busy, standby, link_active, hw_protected, modify_blocked;
  logic out0, out1, out2, out3, oe0, oe1, oe2, oe3;
  logic [7:0] rx;
  logic [23:0] adr [4] = '{24'h000000, 24'h1ff000, 24'h200000, 24'h00f000};
  int fails = 0;
  int checks_done = 0;
  // released line one toggles so a stale value never matches
  wire in1 = oe1 ? out1 : tgl;
  sfpi_host_model u_host (.cs_n(cs_n), .sclk(sclk), .d0(d0), .d2(d2), .d3(d3), .d1(in1));
  sfpi_top u_dut (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chip_select_n(cs_n), .serial_clock(sclk),
    .data_line_zero_in(oe0 ? out0 : d0), .data_line_zero_out(out0), .data_line_zero_oe(oe0),
    .data_line_one_in(in1), .data_line_one_out(out1), .data_line_one_oe(oe1),
    .data_line_two_in(oe2 ? out2 : d2), .data_line_two_out(out2), .data_line_two_oe(oe2),
    .data_line_three_in(oe3 ? out3 : d3), .data_line_three_out(out3), .data_line_three_oe(oe3),
    .op_busy(op_busy), .standby(standby), .link_active(link_active),
    .hw_protected(hw_protected), .modify_blocked(modify_blocked));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    tgl = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) tgl <= ~tgl;
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  // verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      fails++;
      report_and_stop();
    end
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rd_chk
  // pins pass a synchroniser, so give them time
  task automatic settle();
    repeat (8) @(posedge mclk);
  endtask : settle
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {srst, psel, penable, pwrite, op_busy, paddr, pwdata} = {1'b1, 4'h0, 8'h00, 32'h0};
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    settle();
    rd_chk(`SFPI_OFS_STATE, 32'h1); // not armed yet
    chk(standby, 1'b1); // idle standby
    rd_chk(`SFPI_OFS_TXDATA, 32'hff);
    rd_chk(`SFPI_OFS_RANGE, 32'h01ff0000);
    rd_chk(8'h20, 32'h0);
    chk(last_err, 1'b1);
    u_host.pins(1'b1, 1'b0, 1'b1, 1'b1);
    settle();
    rd_chk(`SFPI_OFS_STATE, 32'h1); // high level alone does not arm
    op_busy <= 1'b1;
    settle();
    chk(standby, 1'b0); // busy keeps power
    op_busy <= 1'b0;
    // address map corners
    foreach (adr[i]) begin
      apb(1'b1, `SFPI_OFS_TARGET, {8'h00, adr[i]});
      rd_chk(`SFPI_OFS_MAP, {adr[i] < 24'h200000, 6'h0, adr[i][20:16], 2'h0,
                             adr[i][20:15], 3'h0, adr[i][20:12]});
    end
    // single lane exchange, clock idle low
    apb(1'b1, `SFPI_OFS_TXDATA, 32'h5a);
    apb(1'b1, `SFPI_OFS_CTRL, 32'h4);
    u_host.pins(1'b0, 1'b0, 1'b1, 1'b1);
    settle();
    chk(link_active, 1'b1); // falling edge arms
    u_host.xfer(8'hc3, 8, rx);
    chk({24'h0, rx}, 32'h5a); // sent byte
    settle();
    rd_chk(`SFPI_OFS_RXDATA, 32'hc3); // received byte
    // same exchange with the clock idle high: the opening fall must not shift
    u_host.pins(1'b1, 1'b1, 1'b1, 1'b1);
    u_host.pins(1'b0, 1'b1, 1'b1, 1'b1);
    u_host.xfer(8'h96, 8, rx);
    chk({24'h0, rx}, 32'h5a); // idle high sent byte
    settle();
    rd_chk(`SFPI_OFS_RXDATA, 32'h96); // idle high received byte
    apb(1'b1, `SFPI_OFS_CTRL, 32'hc);
    // pause with clock low, then with clock high
    u_host.pins(1'b0, 1'b0, 1'b0, 1'b1);
    settle();
    rd_chk(`SFPI_OFS_STATE, 32'h8); // pause entered
    chk(oe1, 1'b0); // output released
    u_host.pins(1'b0, 1'b0, 1'b1, 1'b1);
    settle();
    rd_chk(`SFPI_OFS_STATE, 32'h4); // pause left
    u_host.xfer(8'hff, 3, rx);
    u_host.pins(1'b0, 1'b1, 1'b0, 1'b1);
    settle();
    rd_chk(`SFPI_OFS_STATE, 32'h4); // waits for low clock
    u_host.pins(1'b0, 1'b0, 1'b0, 1'b1);
    settle();
    rd_chk(`SFPI_OFS_STATE, 32'h8); // late entry
    u_host.pins(1'b1, 1'b0, 1'b0, 1'b1);
    settle();
    chk({oe0, oe1, oe2, oe3, link_active}, 5'h0); // released pins
    u_host.pins(1'b0, 1'b0, 1'b1, 1'b1);
    u_host.xfer(8'h3c, 8, rx);
    settle();
    rd_chk(`SFPI_OFS_RXDATA, 32'h3c); // partial byte dropped
    u_host.pins(1'b1, 1'b0, 1'b1, 1'b1);
    // hardware protection
    apb(1'b1, `SFPI_OFS_RANGE, 32'h00030002);
    apb(1'b1, `SFPI_OFS_TARGET, 32'h002000);
    apb(1'b1, `SFPI_OFS_PROT, 32'h1);
    u_host.pins(1'b1, 1'b0, 1'b1, 1'b0);
    settle();
    chk({hw_protected, modify_blocked}, 2'h3); // protected
    apb(1'b1, `SFPI_OFS_PROT, 32'h0);
    rd_chk(`SFPI_OFS_PROT, 32'h1); // write refused
    rd_chk(`SFPI_OFS_STATE, 32'hf2); // status flags
    apb(1'b1, `SFPI_OFS_TARGET, 32'h004000);
    settle();
    chk(modify_blocked, 1'b0); // outside range
    u_host.pins(1'b1, 1'b0, 1'b1, 1'b1);
    apb(1'b1, `SFPI_OFS_PROT, 32'h5);
    apb(1'b1, `SFPI_OFS_CTRL, 32'h8);
    u_host.pins(1'b0, 1'b0, 1'b0, 1'b0);
    settle();
    chk(hw_protected, 1'b0); // quad frees pin
    rd_chk(`SFPI_OFS_STATE, 32'h4); // no pause
    u_host.pins(1'b1, 1'b0, 1'b1, 1'b1);
    apb(1'b1, `SFPI_OFS_CTRL, 32'h5);
    u_host.pins(1'b0, 1'b0, 1'b1, 1'b1);
    settle();
    chk({oe0, oe1}, 2'h3); // two lanes driven
    chk({out1, out0}, 2'h1); // first bit pair msb first
    u_host.pins(1'b1, 1'b0, 1'b1, 1'b1);
    apb(1'b1, `SFPI_OFS_CTRL, 32'h6);
    u_host.pins(1'b0, 1'b0, 1'b1, 1'b1);
    settle();
    chk({oe3, oe2, oe1, oe0, out3, out2, out1, out0}, 8'hf5); // quad first nibble
    report_and_stop();
  end
  // hang guard
  initial begin
    #500000;
    fails++;
    report_and_stop();
  end
endmodule : sfpi_top_tb
`default_nettype wire
